/* logic/lcdma_pkg.sv */
// shared constants and types for the link chain dma manager
package lcdma_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFS_CHAN_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHAN_OP = 8'h04;
	localparam logic [7:0] OFS_CHAN_STAT = 8'h08;
	localparam logic [7:0] OFS_MEM_CFG = 8'h0C;
	localparam logic [7:0] OFS_DEV_CFG = 8'h10;
	localparam logic [7:0] OFS_LINK_CFG = 8'h14;
	localparam logic [7:0] OFS_XFER_CNT = 8'h18;
	localparam logic [7:0] OFS_MEM_ADDR = 8'h1C;
	localparam logic [7:0] OFS_DEV_ADDR = 8'h20;
	localparam logic [7:0] OFS_LINK_ADDR = 8'h24;
	localparam logic [7:0] OFS_LAST_LINK = 8'h28;
	localparam logic [7:0] OFS_FIFO_CNT = 8'h2C;
	localparam logic [7:0] OFS_FIFO_DATA = 8'h30;
	// channel operation command bits
	localparam int OP_START = 0;
	localparam int OP_STOP = 1;
	localparam int OP_ABORT = 2;
	localparam int OP_PAUSE_SET = 3;
	localparam int OP_PAUSE_CLR = 4;
	localparam int OP_SOFT_RESET = 5;
	// channel control fields
	localparam int MODE_LSB = 0;
	localparam int WIDTH_LSB = 10;
	localparam int DIR_BIT = 13;
	localparam logic [2:0] MODE_CHAIN = 3'h4;
	localparam logic [1:0] WIDTH_BYTE = 2'h1;
	// channel status bits
	localparam int STAT_DONE = 0;
	localparam int STAT_ACTIVE = 1;
	localparam int STAT_PAUSED = 2;
	localparam int STAT_ERROR = 3;
	localparam int STAT_NATIVE = 4;
	// reset values, sizes and node layout
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam int FIFO_BYTES = 64;
	localparam logic [1:0] NODE_LAST = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01, ST_FETCH = 5'h02, ST_XFER = 5'h04, ST_DRAIN = 5'h08, ST_PAUSE = 5'h10
	} lcdma_state_type;
	// memory master request, held until acknowledged
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} lcdma_mem_type;
	// one-cycle strobes towards the gpib data fifo
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} lcdma_gpib_type;
endpackage : lcdma_pkg

/* logic/lcdma_top.sv */
// link chain dma manager: axi4-lite registers, memory master, staging fifo
// Notes on behaviour
// - own 64-byte staging fifo, moves bytes automatically
// - usable only in native pci 488 mode
// - node is count, block address, next pointer
// - node loads count, memory and link registers
// - chain nodes until count field is zero
// - start fetches node at link address
// - current node address copied to last link
// - every termination sets the done flag
// - soft reset clears registers and staging fifo
// - stop drains staging fifo, accepted in any busy state except drain
// - abort terminates without draining once no access is outstanding, accepted in any busy state except drain
// - pause halts links, clear reloads from memory
// - leftover bytes reported in fifo count bits
// - gpib fifo accesses are sixteen bits wide
// - replicate byte onto unused lanes
// - align memory transfers to dword addresses
`timescale 1ns/100ps
module lcdma_top #(
	parameter int FIFO_BYTES = lcdma_pkg::FIFO_BYTES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite register slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// host memory master
	output lcdma_pkg::lcdma_mem_type mem_out,
	input wire logic mem_ack,
	input wire logic mem_err,
	input wire logic [31:0] mem_rdata,
	// gpib data fifo port
	output lcdma_pkg::lcdma_gpib_type gpib_out,
	input wire logic gpib_ready,
	input wire logic [15:0] gpib_rdata,
	// operating mode strap
	input wire logic native_mode_pin
);
	localparam int PW = $clog2(FIFO_BYTES);
	localparam int CW = PW + 1;

	lcdma_pkg::lcdma_state_type st_reg;
	lcdma_pkg::lcdma_mem_type mem_reg;
	lcdma_pkg::lcdma_gpib_type gpib_reg;
	logic [31:0] channel_control_reg_reg, mcr_reg, dcr_reg, link_port_config_reg_reg, tcr_reg, mar_reg, dar_reg;
	logic [31:0] link_address_reg_reg, last_link_address_reg_reg, dev_left_reg;
	logic done_reg, err_reg, pause_reg, drain_en_reg, node_kind_reg;
	logic [1:0] idx_reg;
	logic [2:0] mem_n_reg, gf_n_reg;
	logic [7:0] fifo_mem [FIFO_BYTES];
	logic [PW-1:0] wp_reg, rp_reg;
	logic [CW-1:0] fcr_reg;
	logic nm_s1_reg, nm_s2_reg;
	logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;

	function automatic logic [31:0] lcdma_merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction : lcdma_merge

	// write channel decode: a write goes once both halves are held
	wire aw_fire = s_axi_awvalid & awready_reg;
	wire w_fire = s_axi_wvalid & wready_reg;
	wire wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire ar_fire = s_axi_arvalid & arready_reg;
	wire aw_full_next = (aw_full_reg | aw_fire) & ~wr_go;
	wire w_full_next = (w_full_reg | w_fire) & ~wr_go;
	wire rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);
	wire wr_map = aw_addr_reg <= lcdma_pkg::OFS_FIFO_DATA && aw_addr_reg[1:0] == 2'h0;
	wire op_wr = wr_go && aw_addr_reg == lcdma_pkg::OFS_CHAN_OP && w_strb_reg[0];
	wire cmd_start = op_wr & w_data_reg[lcdma_pkg::OP_START];
	wire cmd_stop = op_wr & w_data_reg[lcdma_pkg::OP_STOP];
	wire cmd_abort = op_wr & w_data_reg[lcdma_pkg::OP_ABORT];
	wire cmd_pset = op_wr & w_data_reg[lcdma_pkg::OP_PAUSE_SET];
	wire cmd_pclr = op_wr & w_data_reg[lcdma_pkg::OP_PAUSE_CLR];
	wire dma_rst = ~rst_n | (op_wr & w_data_reg[lcdma_pkg::OP_SOFT_RESET]);

	// channel controls and fifo head bytes
	wire idle = st_reg == lcdma_pkg::ST_IDLE;
	wire to_gpib = channel_control_reg_reg[lcdma_pkg::DIR_BIT];
	wire byte_ok = channel_control_reg_reg[lcdma_pkg::WIDTH_LSB +: 2] == lcdma_pkg::WIDTH_BYTE;
	wire chain = channel_control_reg_reg[lcdma_pkg::MODE_LSB +: 3] == lcdma_pkg::MODE_CHAIN;
	wire moving = st_reg == lcdma_pkg::ST_XFER || (st_reg == lcdma_pkg::ST_DRAIN && drain_en_reg);
	wire [CW-1:0] room = CW'(FIFO_BYTES) - fcr_reg;
	wire [7:0] h0 = fifo_mem[rp_reg];
	wire [7:0] h1 = fifo_mem[rp_reg + PW'(1)];
	wire [7:0] h2 = fifo_mem[rp_reg + PW'(2)];
	wire [7:0] h3 = fifo_mem[rp_reg + PW'(3)];
	wire [CW-1:0] mem_avail = to_gpib ? room : fcr_reg;

	// memory side: whole dwords only when aligned and enough bytes remain
	wire mem_word = mar_reg[1:0] == 2'h0 && tcr_reg >= 32'd4 && mem_avail >= CW'(4);
	wire [2:0] mem_n = mem_word ? 3'h4 : 3'h1;
	wire mem_ackd = mem_reg.req & mem_ack;
	wire fetch_go = st_reg == lcdma_pkg::ST_FETCH && ~mem_reg.req;
	wire rd_issue = st_reg == lcdma_pkg::ST_XFER && to_gpib && ~mem_reg.req && tcr_reg != 32'd0
		&& room >= CW'(mem_n);
	wire wr_issue = moving && ~to_gpib && ~mem_reg.req && tcr_reg != 32'd0
		&& fcr_reg >= CW'(mem_n);
	wire issue = fetch_go | rd_issue | wr_issue;
	wire [31:0] wr_word = mem_word ? {h3, h2, h1, h0} : {4{h0}};
	wire [3:0] wr_be = mem_word ? 4'hF : 4'h1 << mar_reg[1:0];

	// gpib side: words, a lone byte only as the last of a block
	wire gf_idle = ~gpib_reg.wr & ~gpib_reg.rd & gpib_ready;
	wire gf_word = dev_left_reg >= 32'd2 && fcr_reg >= CW'(2);
	wire gf_byte = dev_left_reg == 32'd1 && fcr_reg != CW'(0) && byte_ok;
	wire gf_wr_go = moving && to_gpib && gf_idle && (gf_word | gf_byte);
	wire gf_rd_go = st_reg == lcdma_pkg::ST_XFER && ~to_gpib && gf_idle
		&& dev_left_reg != 32'd0 && room >= CW'(2);
	wire [2:0] gf_n = dev_left_reg >= 32'd2 ? 3'h2 : 3'h1;

	// staging fifo traffic: one source pushes and one sink pops per cycle
	wire data_ack = mem_ackd & ~mem_reg.we & ~node_kind_reg;
	wire sw_pop = ar_fire && s_axi_araddr == lcdma_pkg::OFS_FIFO_DATA && idle && fcr_reg != CW'(0);
	wire [31:0] rd_lanes = mem_rdata >> {mar_reg[1:0], 3'h0};
	wire [2:0] push_n = data_ack ? mem_n_reg : (gpib_reg.rd ? gf_n_reg : 3'h0);
	wire [31:0] push_d = data_ack ? rd_lanes : {16'h0000, gpib_rdata};
	wire [2:0] pop_n = gf_wr_go ? gf_n : (wr_issue ? mem_n : (sw_pop ? 3'h1 : 3'h0));
	wire node_end = ~mem_reg.req && tcr_reg == 32'd0
		&& (dev_left_reg == 32'd0 || (to_gpib && dev_left_reg == 32'd1 && ~byte_ok));
	// stop holds the channel up while staged bytes can still reach the gpib fifo
	wire drain_more = drain_en_reg & to_gpib & (gf_word | gf_byte);
	wire drain_done = ~mem_reg.req & ~issue & ~gf_wr_go & ~gpib_reg.rd & ~drain_more;
	wire native = nm_s2_reg;
	wire [31:0] channel_status_reg = {27'h0, native, err_reg, pause_reg, ~idle, done_reg};

	// read data selection
	logic [31:0] rd_mux;
	always_comb begin
		unique case (s_axi_araddr)
			lcdma_pkg::OFS_CHAN_CTRL: rd_mux = channel_control_reg_reg;
			lcdma_pkg::OFS_CHAN_STAT: rd_mux = channel_status_reg;
			lcdma_pkg::OFS_MEM_CFG: rd_mux = mcr_reg;
			lcdma_pkg::OFS_DEV_CFG: rd_mux = dcr_reg;
			lcdma_pkg::OFS_LINK_CFG: rd_mux = link_port_config_reg_reg;
			lcdma_pkg::OFS_XFER_CNT: rd_mux = tcr_reg;
			lcdma_pkg::OFS_MEM_ADDR: rd_mux = mar_reg;
			lcdma_pkg::OFS_DEV_ADDR: rd_mux = dar_reg;
			lcdma_pkg::OFS_LINK_ADDR: rd_mux = link_address_reg_reg;
			lcdma_pkg::OFS_LAST_LINK: rd_mux = last_link_address_reg_reg;
			lcdma_pkg::OFS_FIFO_CNT: rd_mux = {{(32-CW){1'b0}}, fcr_reg};
			lcdma_pkg::OFS_FIFO_DATA: rd_mux = {24'h0, sw_pop ? h0 : 8'h00};
			default: rd_mux = lcdma_pkg::RST_WORD;
		endcase
	end
	wire rd_map = s_axi_araddr <= lcdma_pkg::OFS_FIFO_DATA && s_axi_araddr[1:0] == 2'h0
		&& s_axi_araddr != lcdma_pkg::OFS_CHAN_OP;

	// mode strap crosses in through two flops
	always_ff @(posedge clk) begin
		nm_s1_reg <= native_mode_pin;
		nm_s2_reg <= nm_s1_reg;
	end

	// axi4-lite handshakes; soft reset leaves the bus answer intact
	always_ff @(posedge clk) begin
		if (~rst_n) begin
			{aw_full_reg, w_full_reg, awready_reg, wready_reg} <= 4'h0;
			{bvalid_reg, arready_reg, rvalid_reg} <= 3'h0;
			{bresp_reg, rresp_reg} <= 4'h0;
			rdata_reg <= lcdma_pkg::RST_WORD;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= ~aw_full_next;
			wready_reg <= ~w_full_next;
			bvalid_reg <= wr_go | (bvalid_reg & ~s_axi_bready);
			if (wr_go) bresp_reg <= wr_map ? lcdma_pkg::RESP_OKAY : lcdma_pkg::RESP_DECERR;
			rvalid_reg <= rvalid_next;
			arready_reg <= ~rvalid_next;
			if (ar_fire) begin
				rdata_reg <= rd_mux;
				rresp_reg <= rd_map ? lcdma_pkg::RESP_OKAY : lcdma_pkg::RESP_DECERR;
			end
		end
	end
	// payload latches need no reset: they are only read behind their full flags
	always_ff @(posedge clk) begin
		if (aw_fire) aw_addr_reg <= s_axi_awaddr;
		if (w_fire) begin
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
	end

	// staging fifo storage and pointers
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < push_n) fifo_mem[wp_reg + PW'(i)] <= push_d[8*i +: 8];
		end
		if (dma_rst) begin
			{wp_reg, rp_reg} <= '0;
			fcr_reg <= '0;
		end else begin
			wp_reg <= wp_reg + PW'(push_n);
			rp_reg <= rp_reg + PW'(pop_n);
			fcr_reg <= fcr_reg + CW'(push_n) - CW'(pop_n);
		end
	end

	// memory request stays up until acknowledged
	always_ff @(posedge clk) begin
		if (dma_rst) begin
			mem_reg <= '0;
			node_kind_reg <= 1'b0;
			mem_n_reg <= 3'h0;
		end else if (mem_ackd) begin
			mem_reg.req <= 1'b0;
		end else if (issue) begin
			mem_reg.req <= 1'b1;
			mem_reg.we <= wr_issue;
			mem_reg.addr <= fetch_go ? link_address_reg_reg + {28'h0, idx_reg, 2'h0} : mar_reg;
			mem_reg.wdata <= wr_word;
			mem_reg.be <= fetch_go ? 4'hF : wr_be;
			node_kind_reg <= fetch_go;
			mem_n_reg <= fetch_go ? 3'h4 : mem_n;
		end
	end

	// gpib strobes: one access then a gap, so ready is resampled each time
	always_ff @(posedge clk) begin
		if (dma_rst) begin
			gpib_reg <= '0;
			gf_n_reg <= 3'h0;
		end else begin
			gpib_reg.wr <= gf_wr_go;
			gpib_reg.rd <= gf_rd_go;
			if (gf_wr_go) gpib_reg.wdata <= gf_word ? {h1, h0} : {h0, h0};
			if (gf_rd_go) gf_n_reg <= gf_n;
		end
	end

	// channel registers and sequencer
	always_ff @(posedge clk) begin
		if (dma_rst) begin
			st_reg <= lcdma_pkg::ST_IDLE;
			{channel_control_reg_reg, mcr_reg, dcr_reg, link_port_config_reg_reg} <= {4{lcdma_pkg::RST_WORD}};
			{tcr_reg, mar_reg, dar_reg, link_address_reg_reg} <= {4{lcdma_pkg::RST_WORD}};
			{last_link_address_reg_reg, dev_left_reg} <= {2{lcdma_pkg::RST_WORD}};
			{done_reg, err_reg, pause_reg, drain_en_reg} <= 4'h0;
			idx_reg <= 2'h0;
		end else begin
			if (wr_go) begin
				unique case (aw_addr_reg)
					lcdma_pkg::OFS_CHAN_CTRL: channel_control_reg_reg <= lcdma_merge(channel_control_reg_reg, w_data_reg, w_strb_reg);
					lcdma_pkg::OFS_MEM_CFG: mcr_reg <= lcdma_merge(mcr_reg, w_data_reg, w_strb_reg);
					lcdma_pkg::OFS_DEV_CFG: dcr_reg <= lcdma_merge(dcr_reg, w_data_reg, w_strb_reg);
					lcdma_pkg::OFS_LINK_CFG: link_port_config_reg_reg <= lcdma_merge(link_port_config_reg_reg, w_data_reg, w_strb_reg);
					lcdma_pkg::OFS_DEV_ADDR: dar_reg <= lcdma_merge(dar_reg, w_data_reg, w_strb_reg);
					lcdma_pkg::OFS_XFER_CNT: if (idle) tcr_reg <= lcdma_merge(tcr_reg, w_data_reg, w_strb_reg);
					lcdma_pkg::OFS_MEM_ADDR: if (idle) mar_reg <= lcdma_merge(mar_reg, w_data_reg, w_strb_reg);
					lcdma_pkg::OFS_LINK_ADDR: begin
						if (idle || st_reg == lcdma_pkg::ST_PAUSE)
							link_address_reg_reg <= lcdma_merge(link_address_reg_reg, w_data_reg, w_strb_reg);
					end
					default: ;
				endcase
			end
			if (cmd_pset) pause_reg <= 1'b1;
			if (cmd_pclr) pause_reg <= 1'b0;
			// data beats advance address and count as they are acknowledged
			if (mem_ackd && ~node_kind_reg) begin
				mar_reg <= mar_reg + 32'(mem_n_reg);
				tcr_reg <= tcr_reg - 32'(mem_n_reg);
			end
			if (gf_wr_go || gf_rd_go) dev_left_reg <= dev_left_reg - 32'(gf_n);
			unique case (st_reg)
				lcdma_pkg::ST_IDLE: begin
					if (cmd_start && native) begin
						done_reg <= 1'b0;
						err_reg <= 1'b0;
						idx_reg <= 2'h0;
						if (chain) begin
							st_reg <= lcdma_pkg::ST_FETCH;
							last_link_address_reg_reg <= link_address_reg_reg;
						end else begin
							// a block restart also covers bytes still staged
							dev_left_reg <= to_gpib ? tcr_reg + 32'(fcr_reg) : tcr_reg - 32'(fcr_reg);
							st_reg <= lcdma_pkg::ST_XFER;
						end
					end
				end
				lcdma_pkg::ST_FETCH: begin
					if (mem_ackd && node_kind_reg) begin
						idx_reg <= idx_reg + 2'h1;
						unique case (idx_reg)
							2'h0: begin
								tcr_reg <= mem_rdata;
								dev_left_reg <= mem_rdata;
							end
							2'h1: mar_reg <= mem_rdata;
							default: link_address_reg_reg <= mem_rdata;
						endcase
						if (idx_reg == 2'h0 && mem_rdata == 32'd0) begin
							st_reg <= lcdma_pkg::ST_IDLE;
							done_reg <= 1'b1;
						end else if (idx_reg == lcdma_pkg::NODE_LAST) begin
							st_reg <= lcdma_pkg::ST_XFER;
						end
					end
				end
				lcdma_pkg::ST_XFER: begin
					if (node_end && chain) begin
						idx_reg <= 2'h0;
						last_link_address_reg_reg <= link_address_reg_reg;
						if (pause_reg) begin
							st_reg <= lcdma_pkg::ST_PAUSE;
							done_reg <= 1'b1;
						end else begin
							st_reg <= lcdma_pkg::ST_FETCH;
						end
					end else if (node_end) begin
						st_reg <= lcdma_pkg::ST_IDLE;
						done_reg <= 1'b1;
					end
				end
				lcdma_pkg::ST_PAUSE: begin
					if (cmd_pclr) begin
						idx_reg <= 2'h0;
						last_link_address_reg_reg <= link_address_reg_reg;
						st_reg <= lcdma_pkg::ST_FETCH;
					end
				end
				lcdma_pkg::ST_DRAIN: begin
					if (drain_done) begin
						st_reg <= lcdma_pkg::ST_IDLE;
						done_reg <= 1'b1;
					end
				end
			endcase
			// stop and abort win over the normal flow in any busy state except drain
			if (~idle && st_reg != lcdma_pkg::ST_DRAIN && (cmd_stop || cmd_abort)) begin
				st_reg <= lcdma_pkg::ST_DRAIN;
				drain_en_reg <= cmd_stop & ~cmd_abort;
			end
			// a bus error ends the channel at once
			if (mem_ackd && mem_err) begin
				st_reg <= lcdma_pkg::ST_IDLE;
				err_reg <= 1'b1;
				done_reg <= 1'b1;
			end
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign mem_out = mem_reg;
	assign gpib_out = gpib_reg;
endmodule : lcdma_top

/* sim/lcdma_chk.sv */
// concurrent checks on the link chain dma manager ports
`timescale 1ns/100ps
module lcdma_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register bus answers
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// memory and gpib sides
	input wire lcdma_pkg::lcdma_mem_type mem_out,
	input wire logic mem_ack,
	input wire lcdma_pkg::lcdma_gpib_type gpib_out,
	input wire logic gpib_ready
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// bus answers stand until taken; reads answer one cycle after the take
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("bresp dropped early");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata dropped early");
	property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_r_dec;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h30
			|=> s_axi_rresp == lcdma_pkg::RESP_DECERR && s_axi_rdata == 32'h0;
	endproperty
	a_r_dec: assert property (p_r_dec) else $error("unmapped read not refused");
	// the memory request keeps its address until acknowledged, then drops
	property p_m_hold; mem_out.req && !mem_ack |=> !mem_out.req || $stable(mem_out.addr); endproperty
	a_m_hold: assert property (p_m_hold) else $error("memory address moved");
	property p_m_gap; mem_out.req && mem_ack |=> !mem_out.req; endproperty
	a_m_gap: assert property (p_m_gap) else $error("memory request not dropped");
	// gpib strobes are single pulses, only after the fifo said ready
	property p_g_gap; gpib_out.wr || gpib_out.rd |=> !gpib_out.wr && !gpib_out.rd; endproperty
	a_g_gap: assert property (p_g_gap) else $error("gpib strobes too close");
	property p_g_rdy; gpib_out.wr || gpib_out.rd |-> $past(gpib_ready); endproperty
	a_g_rdy: assert property (p_g_rdy) else $error("gpib strobe without ready");
endmodule : lcdma_chk
bind lcdma_top lcdma_chk i_lcdma_chk (.clk(clk), .rst_n(rst_n), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.mem_out(mem_out), .mem_ack(mem_ack), .gpib_out(gpib_out), .gpib_ready(gpib_ready));

/* sim/lcdma_mem_model.sv */
// host memory model answering the dma manager's master port
`timescale 1ns/100ps
module lcdma_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// answer delay in cycles
	input wire logic [3:0] lat,
	// master port of the dma manager
	input wire lcdma_pkg::lcdma_mem_type mem_out,
	output logic mem_ack,
	output logic mem_err,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [0:255];
	logic [3:0] wait_reg;
	wire [7:0] idx = mem_out.addr[9:2];
	assign mem_err = 1'b0; // this memory never refuses
	// stall, then answer for one cycle; rdata toggles outside answers so stale data shows
	always @(posedge clk) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			wait_reg <= 4'h0;
			mem_rdata <= 32'h0;
		end else if (mem_out.req && !mem_ack && wait_reg >= lat) begin
			mem_ack <= 1'b1;
			wait_reg <= 4'h0;
			mem_rdata <= mem[idx];
			for (int b = 0; b < 4; b++) begin
				if (mem_out.we && mem_out.be[b]) mem[idx][8*b +: 8] <= mem_out.wdata[8*b +: 8];
			end
		end else begin
			mem_ack <= 1'b0;
			wait_reg <= (mem_out.req && !mem_ack) ? wait_reg + 4'h1 : 4'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : lcdma_mem_model

/* sim/test_link_chain_dma_manager.sv */
// self-checking bench for the link chain dma manager
`timescale 1ns/100ps
module test_link_chain_dma_manager;
	// bench-driven inputs and observed outputs
	logic clk, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, gready = 1'b1, native = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, mack, merr;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, mrd;
	logic [3:0] wstrb = 4'hF, lat = 4'h0;
	logic [1:0] bresp, rresp;
	lcdma_pkg::lcdma_mem_type mout;
	lcdma_pkg::lcdma_gpib_type gout;
	logic [15:0] q[$];
	int fail_count = 0, check_count = 0;
	// device and its host memory
	lcdma_top i_lcdma_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .mem_out(mout), .mem_ack(mack), .mem_err(merr),
		.mem_rdata(mrd), .gpib_out(gout), .gpib_ready(gready), .gpib_rdata(16'h0),
		.native_mode_pin(native));
	lcdma_mem_model i_lcdma_mem_model (.clk(clk), .rst_n(rst_n), .lat(lat), .mem_out(mout),
		.mem_ack(mack), .mem_err(merr), .mem_rdata(mrd));
	// clock, and a log of every word that reaches the gpib fifo
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (gout.wr === 1'b1) q.push_back(gout.wdata); // dma only
	task close_out;
		if (fail_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task stuck(input string n);
		fail_count++;
		$display("[FAIL] %s expected answer seen none", n);
		close_out;
	endtask : stuck
	// bus tasks sample at the falling edge and change after the rising one; bready and
	// rready rise only once valid is seen, so the answer must stand a cycle unanswered
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb, tv;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		tb = 1'b0;
		for (int n = 0; n < 300 && !tb; n++) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			tv = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			bready <= tv && !tb;
		end
		if (!tb) stuck("write");
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tb, tv;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		tb = 1'b0;
		for (int n = 0; n < 300 && !tb; n++) begin
			@(negedge clk);
			ta = arvalid && arready;
			tb = rvalid && rready;
			tv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			rready <= tv && !tb;
		end
		if (!tb) stuck("read");
	endtask : rd
	task wreg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", 32'h0, 32'(r));
	endtask : wreg
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(n, e, d);
	endtask : rchk
	task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		for (n = 0; n < 300; n++) begin
			rd(a, d, r);
			if ((d & m) === v) break;
		end
		if (n == 300) stuck("status");
	endtask : poll
	task chain_cfg;
		wreg(lcdma_pkg::OFS_CHAN_CTRL, 32'h0000_2404);
		wreg(lcdma_pkg::OFS_LINK_ADDR, 32'h0000_0100);
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0001);
	endtask : chain_cfg
	task s_regs;
		logic [31:0] d;
		logic [1:0] r;
		rchk("status", lcdma_pkg::OFS_CHAN_STAT, 32'h10);
		rchk("link", lcdma_pkg::OFS_LINK_ADDR, 32'h0);
		rd(8'h34, d, r);
		chk("unmapped rresp", 32'h3, 32'(r));
		rd(lcdma_pkg::OFS_CHAN_OP, d, r);
		chk("op rresp", 32'h3, 32'(r));
		wr(8'h40, 32'hFFFF_FFFF, r);
		chk("unmapped bresp", 32'h3, 32'(r));
	endtask : s_regs
	task s_chain;
		lat <= 4'h6;
		i_lcdma_mem_model.mem[64] = 32'h0000_0004;
		i_lcdma_mem_model.mem[65] = 32'h0000_0200;
		i_lcdma_mem_model.mem[66] = 32'h0000_010C;
		i_lcdma_mem_model.mem[67] = 32'h0000_0003;
		i_lcdma_mem_model.mem[68] = 32'h0000_0300;
		i_lcdma_mem_model.mem[69] = 32'h0000_0118;
		i_lcdma_mem_model.mem[70] = 32'h0000_0000;
		i_lcdma_mem_model.mem[128] = 32'h4433_2211;
		i_lcdma_mem_model.mem[192] = 32'h8877_6655;
		chain_cfg;
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0008);
		poll(lcdma_pkg::OFS_CHAN_STAT, 32'h5, 32'h5);
		rchk("last link", lcdma_pkg::OFS_LAST_LINK, 32'h10C);
		rchk("link", lcdma_pkg::OFS_LINK_ADDR, 32'h10C);
		chk("words", 32'h2, 32'(q.size()));
		chk("word0", 32'h2211, 32'(q[0]));
		chk("word1", 32'h4433, 32'(q[1]));
		wreg(lcdma_pkg::OFS_LINK_ADDR, 32'h0000_010C);
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0010);
		poll(lcdma_pkg::OFS_CHAN_STAT, 32'h6, 32'h0);
		chk("words", 32'h4, 32'(q.size()));
		chk("word2", 32'h6655, 32'(q[2]));
		chk("word3", 32'h7777, 32'(q[3]));
		rchk("status", lcdma_pkg::OFS_CHAN_STAT, 32'h11);
	endtask : s_chain
	task s_block;
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0020);
		rchk("link", lcdma_pkg::OFS_LINK_ADDR, 32'h0);
		rchk("status", lcdma_pkg::OFS_CHAN_STAT, 32'h10);
		q.delete();
		// single block, two-byte elements, odd count leaves one byte staged
		wreg(lcdma_pkg::OFS_CHAN_CTRL, 32'h0000_2800);
		wreg(lcdma_pkg::OFS_XFER_CNT, 32'h0000_0003);
		wreg(lcdma_pkg::OFS_MEM_ADDR, 32'h0000_0300);
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0001);
		poll(lcdma_pkg::OFS_CHAN_STAT, 32'h3, 32'h1);
		chk("words", 32'h1, 32'(q.size()));
		chk("word0", 32'h6655, 32'(q[0]));
		rchk("fifo count", lcdma_pkg::OFS_FIFO_CNT, 32'h1);
		rchk("fifo byte", lcdma_pkg::OFS_FIFO_DATA, 32'h77);
		rchk("fifo count", lcdma_pkg::OFS_FIFO_CNT, 32'h0);
	endtask : s_block
	task s_abort;
		logic [31:0] d;
		logic [1:0] r;
		gready <= 1'b0;
		lat <= 4'h0;
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0020);
		q.delete();
		chain_cfg;
		poll(lcdma_pkg::OFS_FIFO_CNT, 32'h4, 32'h4);
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0004);
		poll(lcdma_pkg::OFS_CHAN_STAT, 32'h1, 32'h1);
		rd(lcdma_pkg::OFS_FIFO_CNT, d, r);
		chk("kept bytes", 32'h1, 32'(d[6:0] != 7'h0));
		chk("words", 32'h0, 32'(q.size()));
	endtask : s_abort
	task s_stop;
		logic [31:0] d;
		logic [1:0] r;
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0020);
		chain_cfg;
		poll(lcdma_pkg::OFS_FIFO_CNT, 32'h4, 32'h4);
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0002);
		rd(lcdma_pkg::OFS_CHAN_STAT, d, r);
		chk("done early", 32'h0, 32'(d[0]));
		gready <= 1'b1;
		poll(lcdma_pkg::OFS_CHAN_STAT, 32'h3, 32'h1);
		rchk("fifo count", lcdma_pkg::OFS_FIFO_CNT, 32'h0);
		chk("drained", 32'h1, 32'(q.size() >= 2));
	endtask : s_stop
	task s_native;
		native <= 1'b0;
		wreg(lcdma_pkg::OFS_CHAN_OP, 32'h0000_0020);
		q.delete();
		chain_cfg;
		rchk("status", lcdma_pkg::OFS_CHAN_STAT, 32'h0);
		chk("words", 32'h0, 32'(q.size()));
		native <= 1'b1;
	endtask : s_native
	// reset for ten cycles, let the mode strap settle, then run each scenario
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		s_regs;
		s_chain;
		s_block;
		s_abort;
		s_stop;
		s_native;
		close_out;
	end
endmodule : test_link_chain_dma_manager
